// ### rtl/mpp_pkg.sv
// constants, encodings and helper functions of the manchester programming port
package mpp_pkg;

  localparam int unsigned CLK_FREQ_HZ       = 10_000_000;
  localparam int unsigned KEY_WINDOW_MS     = 500;
  // divide first: the product in hertz would overflow 32 bits
  localparam int unsigned KEY_WINDOW_CYCLES = CLK_FREQ_HZ / 1000 * KEY_WINDOW_MS;
  localparam int unsigned TIMER_W           = 23;

  // bit period counter; 12 bits hold 2500 cycles of the slowest 4 kbit/s link
  localparam int unsigned PERIOD_W          = 12;
  localparam logic [11:0] MIN_BIT_CYCLES    = 12'h004;
  localparam logic [11:0] MAX_BIT_CYCLES    = 12'hFFF;

  // bit counts after the sync pair; the ack frame count includes the sync pair
  localparam logic [5:0]  RD_FRAME_BITS     = 6'h11;
  localparam logic [5:0]  WR_FRAME_BITS     = 6'h31;
  localparam logic [5:0]  CNT_SATURATE      = 6'h3F;
  localparam logic [5:0]  ACK_FRAME_BITS    = 6'h25;
  localparam logic [1:0]  SYNC_PATTERN      = 2'h0;

  localparam logic [2:0]  CRC_PRESET        = 3'h7;
  localparam logic [2:0]  CRC_GOOD          = 3'h0;

  localparam logic [3:0]  CS_BCAST_NONE     = 4'h0;
  localparam logic [3:0]  CS_BCAST_ALL      = 4'hF;

  localparam logic [1:0]  FS_ALL            = 2'h0;
  localparam logic [1:0]  FS_LOW            = 2'h1;
  localparam logic [1:0]  FS_HIGH           = 2'h2;
  localparam logic [1:0]  FS_UNUSED         = 2'h3;
  localparam logic [31:0] MASK_ALL          = 32'hFFFF_FFFF;
  localparam logic [31:0] MASK_LOW          = 32'h0000_0FFF;
  localparam logic [31:0] MASK_HIGH         = 32'h03FF_F000;
  localparam logic [31:0] MASK_NONE         = 32'h0000_0000;

  localparam logic [1:0]  REGION_EEPROM     = 2'h0;
  localparam logic [1:0]  REGION_SHADOW     = 2'h1;
  localparam logic [1:0]  REGION_VOLATILE   = 2'h2;
  localparam logic [4:0]  FACTORY_LAST_ROW  = 5'h01;

  localparam logic [6:0]  KEY_ADDR          = 7'h79;
  localparam logic [31:0] KEY_DATA          = 32'hC41D_3432;

  localparam logic [2:0]  LOCK_NO_EE_WRITE  = 3'h3;
  localparam logic [2:0]  LOCK_SEALED       = 3'h5;
  localparam logic [2:0]  LOCK_READ_ONLY    = 3'h6;

  localparam logic [6:0]  MARGIN_DATA_ADDR  = 7'h41;
  localparam logic [6:0]  MARGIN_STAT_ADDR  = 7'h42;
  localparam logic [6:0]  MARGIN_CTRL_ADDR  = 7'h43;
  localparam int unsigned MARGIN_START_BIT  = 0;
  localparam int unsigned MARGIN_MODE_LSB   = 1;
  localparam logic [25:0] MARGIN_RESET      = 26'h000_0000;

  // shift-register form: running it over the crc bits too leaves zero
  function automatic logic [2:0] crc3_step(input logic [2:0] crc, input logic din);
    logic fb;
    fb = crc[2] ^ din;
    return {crc[1], crc[0] ^ fb, fb};
  endfunction : crc3_step

  function automatic logic [1:0] addr_region(input logic [6:0] addr);
    if (addr[6]) return REGION_VOLATILE;
    if (addr[5]) return REGION_SHADOW;
    return REGION_EEPROM;
  endfunction : addr_region

  function automatic logic [31:0] field_mask(input logic [1:0] fs);
    case (fs)
      FS_ALL:  return MASK_ALL;
      FS_LOW:  return MASK_LOW;
      FS_HIGH: return MASK_HIGH;
      default: return MASK_NONE;
    endcase
  endfunction : field_mask

endpackage : mpp_pkg

// ### rtl/mpp_rx.sv
// manchester receiver: measures the bit time on the sync pair and slices bits
`timescale 1ns/1ps
`default_nettype none
module mpp_rx (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        enable,
  input  wire logic                        line,
  output logic                             bit_stb,
  output logic                             bit_val,
  output logic                             frame_end,
  output logic [mpp_pkg::PERIOD_W-1:0]     bit_period
);

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_MEAS = 2'b01,
    RX_RUN  = 2'b10
  } mpp_rx_state_t;

  mpp_rx_state_t                 state_reg;
  logic                          line_d_reg;
  logic [mpp_pkg::PERIOD_W:0]    cnt_reg;
  logic [mpp_pkg::PERIOD_W:0]    early;
  logic [mpp_pkg::PERIOD_W:0]    late;
  logic                          rise;
  logic                          fall;

  assign rise  = line & ~line_d_reg;
  assign fall  = ~line & line_d_reg;
  // mid-bit edges are expected 3/4..5/4 of a period after the previous one
  assign early = {1'b0, bit_period} - {3'b000, bit_period[mpp_pkg::PERIOD_W-1:2]};
  assign late  = {1'b0, bit_period} + {3'b000, bit_period[mpp_pkg::PERIOD_W-1:2]};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      line_d_reg <= 1'b0;
    end else begin
      line_d_reg <= line;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= RX_IDLE;
      cnt_reg    <= '0;
      bit_period <= '0;
      bit_stb    <= 1'b0;
      bit_val    <= 1'b0;
      frame_end  <= 1'b0;
    end else begin
      bit_stb   <= 1'b0;
      frame_end <= 1'b0;
      if (!enable) begin
        state_reg <= RX_IDLE;
      end else begin
        case (state_reg)
          RX_IDLE: begin
            if (rise) begin
              cnt_reg   <= 13'h0001;
              state_reg <= RX_MEAS;
            end
          end
          // rise to rise spans one bit
          RX_MEAS: begin
            if (rise && cnt_reg[mpp_pkg::PERIOD_W-1:0] >= mpp_pkg::MIN_BIT_CYCLES) begin
              bit_period <= cnt_reg[mpp_pkg::PERIOD_W-1:0];
              cnt_reg    <= 13'h0001;
              state_reg  <= RX_RUN;
            end else if (cnt_reg[mpp_pkg::PERIOD_W-1:0] == mpp_pkg::MAX_BIT_CYCLES) begin
              state_reg <= RX_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 13'h0001;
            end
          end
          RX_RUN: begin
            if ((rise || fall) && cnt_reg >= early) begin
              bit_stb <= 1'b1;
              bit_val <= fall;
              cnt_reg <= 13'h0001;
            end else if (cnt_reg >= late) begin
              frame_end <= 1'b1;
              state_reg <= RX_IDLE;
            end else begin
              cnt_reg <= cnt_reg + 13'h0001;
            end
          end
          default: state_reg <= RX_IDLE;
        endcase
      end
    end
  end

endmodule : mpp_rx
`default_nettype wire

// ### rtl/mpp_tx.sv
// manchester transmitter for the read acknowledge frame
`timescale 1ns/1ps
`default_nettype none
module mpp_tx (
  input  wire logic                        sys_clk,
  input  wire logic                        rstn,
  input  wire logic                        start,
  input  wire logic [36:0]                 frame,
  input  wire logic [mpp_pkg::PERIOD_W-1:0] half_period,
  output logic                             busy,
  output logic                             pin_out,
  output logic                             pin_oe
);

  logic [36:0]                  shift_reg;
  logic [5:0]                   left_reg;
  logic                         second_reg;
  logic [mpp_pkg::PERIOD_W-1:0] cnt_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      shift_reg  <= '0;
      left_reg   <= '0;
      second_reg <= 1'b0;
      cnt_reg    <= '0;
      busy       <= 1'b0;
      pin_out    <= 1'b0;
      pin_oe     <= 1'b0;
    end else if (start && !busy) begin
      shift_reg  <= frame;
      left_reg   <= mpp_pkg::ACK_FRAME_BITS;
      second_reg <= 1'b0;
      cnt_reg    <= half_period;
      busy       <= 1'b1;
      pin_out    <= frame[36];
      pin_oe     <= 1'b1;
    end else if (busy) begin
      if (cnt_reg > 12'h001) begin
        cnt_reg <= cnt_reg - 12'h001;
      end else begin
        cnt_reg <= half_period;
        if (!second_reg) begin
          second_reg <= 1'b1;
          pin_out    <= ~shift_reg[36];
        end else begin
          second_reg <= 1'b0;
          shift_reg  <= {shift_reg[35:0], 1'b0};
          left_reg   <= left_reg - 6'h01;
          if (left_reg == 6'h01) begin
            busy    <= 1'b0;
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
          end else begin
            pin_out <= shift_reg[35];
          end
        end
      end
    end
  end

endmodule : mpp_tx
`default_nettype wire

// ### rtl/mpp_port.sv
// command interpreter of the manchester programming port
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - falling mid-bit is one, rising is zero
// - bit time from controller, reply same rate
// - sync, rw, cs, fs, address, data, crc
// - unlock key frame carries 32 data bits
// - read frame: address then crc, no data
// - two zero sync bits measure bit time
// - chip select bit per die, 0000/1111 broadcast
// - field select whole, low or high part
// - address ranges: eeprom, shadow, volatile
// - data word is 26 bits plus 6 ecc
// - crc skips the sync bits
// - crc polynomial x3+x+1 preset 111
// - last three bits are crc, checked
// - unlock only within 500 ms of reset
// - key is address 0x79, data 0xC41D3432
// - after unlock factory rows read only
// - lock 0,1,2,4,7 give full access
// - lock 3 blocks eeprom writes only
// - lock 6 blocks all writes
// - lock 5 blocks reads and writes
// - margin start at 0x43, results 0x41/0x42
// - margin needs unlock, ones/zeros/both modes
// - margin fail gives no diagnostic output
// - never talks first, answers reads only
module mpp_port #(
  parameter int unsigned KEY_WINDOW_CYCLES = mpp_pkg::KEY_WINDOW_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        prog_en,
  input  wire logic        prog_data_in,
  output logic             prog_data_out,
  output logic             prog_data_oe,
  input  wire logic [1:0]  die_addr,
  input  wire logic [2:0]  dev_lock,
  output logic             mem_req,
  output logic             mem_we,
  output logic [1:0]       mem_region,
  output logic [6:0]       mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [31:0]      mem_wmask,
  input  wire logic [31:0] mem_rdata,
  output logic             margin_start,
  output logic [1:0]       margin_mode,
  input  wire logic        margin_done,
  input  wire logic [25:0] margin_result_data,
  input  wire logic [25:0] margin_result_status,
  output logic             unlocked,
  output logic             key_window_open
);

  typedef enum logic [2:0] {
    ST_LISTEN  = 3'b000,
    ST_DECODE  = 3'b001,
    ST_RD_WAIT = 3'b010,
    ST_RD_CAP  = 3'b011,
    ST_GAP     = 3'b100,
    ST_SEND    = 3'b101
  } mpp_state_t;

  mpp_state_t                   state_reg;
  logic [1:0]                   en_sync_reg;
  logic [1:0]                   din_sync_reg;
  logic [48:0]                  frm_reg;
  logic [5:0]                   cnt_reg;
  logic [2:0]                   crc_reg;
  logic [mpp_pkg::TIMER_W-1:0]  timer_reg;
  logic [25:0]                  margin_ctrl_reg;
  logic [25:0]                  margin_data_reg;
  logic [25:0]                  margin_stat_reg;
  logic [31:0]                  ack_data_reg;
  logic [31:0]                  rd_mask_reg;
  logic [mpp_pkg::PERIOD_W:0]   gap_reg;
  logic                         tx_start_reg;

  logic                         rx_enable;
  logic                         rx_bit_stb;
  logic                         rx_bit_val;
  logic                         rx_frame_end;
  logic [mpp_pkg::PERIOD_W-1:0] rx_period;
  logic                         tx_busy;

  logic                         is_rd;
  logic                         is_wr;
  logic [3:0]                   f_cs;
  logic [1:0]                   f_fs;
  logic [6:0]                   f_addr;
  logic [31:0]                  f_data;
  logic [31:0]                  f_mask;
  logic                         cs_hit;
  logic                         frame_ok;
  logic                         key_hit;
  logic                         factory_row;
  logic                         wr_ok;
  logic                         rd_ok;
  logic                         margin_addr;
  logic                         do_write;
  logic                         do_margin_wr;
  logic                         do_read;

  function automatic logic [2:0] crc3_word(input logic [31:0] word);
    logic [2:0] c;
    c = mpp_pkg::CRC_PRESET;
    for (int i = 31; i >= 0; i--) begin
      c = mpp_pkg::crc3_step(c, word[i]);
    end
    return c;
  endfunction : crc3_word

  // pins come from outside the clock domain
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      en_sync_reg  <= 2'h0;
      din_sync_reg <= 2'h0;
    end else begin
      en_sync_reg  <= {en_sync_reg[0], prog_en};
      din_sync_reg <= {din_sync_reg[0], prog_data_in};
    end
  end

  assign rx_enable = en_sync_reg[1] && (state_reg == ST_LISTEN);

  mpp_rx u_rx (
    .sys_clk    (sys_clk),
    .rstn       (rstn),
    .enable     (rx_enable),
    .line       (din_sync_reg[1]),
    .bit_stb    (rx_bit_stb),
    .bit_val    (rx_bit_val),
    .frame_end  (rx_frame_end),
    .bit_period (rx_period)
  );

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timer_reg       <= '0;
      key_window_open <= 1'b1;
    end else if (key_window_open) begin
      timer_reg <= timer_reg + 23'h00_0001;
      if (timer_reg == KEY_WINDOW_CYCLES[mpp_pkg::TIMER_W-1:0] - 23'h00_0001) begin
        key_window_open <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      frm_reg <= '0;
      cnt_reg <= '0;
      crc_reg <= mpp_pkg::CRC_PRESET;
    end else if (!rx_enable) begin
      cnt_reg <= '0;
      crc_reg <= mpp_pkg::CRC_PRESET;
    end else if (rx_bit_stb) begin
      frm_reg <= {frm_reg[47:0], rx_bit_val};
      crc_reg <= mpp_pkg::crc3_step(crc_reg, rx_bit_val);
      if (cnt_reg != mpp_pkg::CNT_SATURATE) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  always_comb begin
    is_rd = (cnt_reg == mpp_pkg::RD_FRAME_BITS) && frm_reg[16];
    is_wr = (cnt_reg == mpp_pkg::WR_FRAME_BITS) && !frm_reg[48];
    if (is_rd) begin
      f_cs   = frm_reg[15:12];
      f_fs   = frm_reg[11:10];
      f_addr = frm_reg[9:3];
    end else begin
      f_cs   = frm_reg[47:44];
      f_fs   = frm_reg[43:42];
      f_addr = frm_reg[41:35];
    end
    f_data = frm_reg[34:3];
    f_mask = mpp_pkg::field_mask(f_fs);
    cs_hit = (f_cs == mpp_pkg::CS_BCAST_NONE) || (f_cs == mpp_pkg::CS_BCAST_ALL) ||
             f_cs[die_addr];
    // crc over crc bits leaves zero
    frame_ok = (is_rd || is_wr) && cs_hit && (crc_reg == mpp_pkg::CRC_GOOD);
    // address and data form the key
    key_hit  = frame_ok && is_wr && (f_addr == mpp_pkg::KEY_ADDR) &&
               (f_data == mpp_pkg::KEY_DATA);
    factory_row = !f_addr[6] && (f_addr[4:0] <= mpp_pkg::FACTORY_LAST_ROW);
    wr_ok = unlocked && !factory_row;
    case (dev_lock)
      mpp_pkg::LOCK_NO_EE_WRITE: wr_ok = wr_ok &&
        (mpp_pkg::addr_region(f_addr) != mpp_pkg::REGION_EEPROM);
      mpp_pkg::LOCK_READ_ONLY:   wr_ok = 1'b0;
      mpp_pkg::LOCK_SEALED:      wr_ok = 1'b0;
      default:                   wr_ok = wr_ok;
    endcase
    rd_ok       = (dev_lock != mpp_pkg::LOCK_SEALED);
    margin_addr = (f_addr == mpp_pkg::MARGIN_DATA_ADDR) ||
                  (f_addr == mpp_pkg::MARGIN_STAT_ADDR) ||
                  (f_addr == mpp_pkg::MARGIN_CTRL_ADDR);
    // bad frames and fs 3 drop out here
    do_write     = frame_ok && is_wr && !key_hit && (f_fs != mpp_pkg::FS_UNUSED) && wr_ok;
    // margin control needs unlock via wr_ok
    do_margin_wr = do_write && (f_addr == mpp_pkg::MARGIN_CTRL_ADDR);
    do_read      = frame_ok && is_rd && (f_fs != mpp_pkg::FS_UNUSED) && rd_ok;
  end

  // key counts only inside the window
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      unlocked <= 1'b0;
    end else if (state_reg == ST_DECODE && key_hit && key_window_open) begin
      unlocked <= 1'b1;
    end
  end

  // region decode on the memory port
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_region <= mpp_pkg::REGION_EEPROM;
      mem_addr   <= '0;
      mem_wdata  <= '0;
      mem_wmask  <= '0;
    end else begin
      mem_req <= 1'b0;
      if (state_reg == ST_DECODE && !margin_addr && (do_write || do_read)) begin
        mem_req    <= 1'b1;
        mem_we     <= do_write;
        mem_region <= mpp_pkg::addr_region(f_addr);
        mem_addr   <= f_addr;
        mem_wdata  <= f_data;
        mem_wmask  <= f_mask;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      margin_ctrl_reg <= mpp_pkg::MARGIN_RESET;
      margin_start    <= 1'b0;
    end else begin
      margin_start <= 1'b0;
      // a new start beats a done in the same cycle
      if (state_reg == ST_DECODE && do_margin_wr) begin
        margin_ctrl_reg <= (margin_ctrl_reg & ~f_mask[25:0]) | (f_data[25:0] & f_mask[25:0]);
        margin_start    <= f_data[mpp_pkg::MARGIN_START_BIT] &&
                           f_mask[mpp_pkg::MARGIN_START_BIT];
      end else if (margin_done) begin
        margin_ctrl_reg[mpp_pkg::MARGIN_START_BIT] <= 1'b0;
      end
    end
  end

  // 0 both, 1 ones only, 2 zeros only
  assign margin_mode = margin_ctrl_reg[mpp_pkg::MARGIN_MODE_LSB +: 2];

  // failures only land in the result words
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      margin_data_reg <= mpp_pkg::MARGIN_RESET;
      margin_stat_reg <= mpp_pkg::MARGIN_RESET;
    end else if (margin_done) begin
      margin_data_reg <= margin_result_data;
      margin_stat_reg <= margin_result_status;
    end
  end

  // command sequencing and acknowledge assembly
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_LISTEN;
      ack_data_reg <= '0;
      rd_mask_reg  <= '0;
      gap_reg      <= '0;
      tx_start_reg <= 1'b0;
    end else begin
      tx_start_reg <= 1'b0;
      case (state_reg)
        ST_LISTEN: begin
          if (rx_frame_end) begin
            state_reg <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          rd_mask_reg <= f_mask;
          gap_reg     <= {1'b0, rx_period};
          if (!do_read) begin
            state_reg <= ST_LISTEN;
          end else if (f_addr == mpp_pkg::MARGIN_DATA_ADDR) begin
            ack_data_reg <= {6'h00, margin_data_reg} & f_mask;
            state_reg    <= ST_GAP;
          end else if (f_addr == mpp_pkg::MARGIN_STAT_ADDR) begin
            ack_data_reg <= {6'h00, margin_stat_reg} & f_mask;
            state_reg    <= ST_GAP;
          end else if (f_addr == mpp_pkg::MARGIN_CTRL_ADDR) begin
            ack_data_reg <= {6'h00, margin_ctrl_reg} & f_mask;
            state_reg    <= ST_GAP;
          end else begin
            state_reg <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: begin
          state_reg <= ST_RD_CAP;
        end
        ST_RD_CAP: begin
          ack_data_reg <= mem_rdata & rd_mask_reg;
          state_reg    <= ST_GAP;
        end
        ST_GAP: begin
          // one idle bit lets the controller release the line
          if (gap_reg <= 13'h0001) begin
            tx_start_reg <= 1'b1;
            state_reg    <= ST_SEND;
          end else begin
            gap_reg <= gap_reg - 13'h0001;
          end
        end
        ST_SEND: begin
          // receiver stays off during the reply
          if (!tx_busy && !tx_start_reg) begin
            state_reg <= ST_LISTEN;
          end
        end
        default: state_reg <= ST_LISTEN;
      endcase
    end
  end

  mpp_tx u_tx (
    .sys_clk     (sys_clk),
    .rstn        (rstn),
    .start       (tx_start_reg),
    .frame       ({mpp_pkg::SYNC_PATTERN, ack_data_reg, crc3_word(ack_data_reg)}),
    .half_period ({1'b0, rx_period[mpp_pkg::PERIOD_W-1:1]}),
    .busy        (tx_busy),
    .pin_out     (prog_data_out),
    .pin_oe      (prog_data_oe)
  );

endmodule : mpp_port
`default_nettype wire

// ### tb/mpp_mem_model.sv
// memory and margin engine behind the programming port
`timescale 1ns/1ps
`default_nettype none
module mpp_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [6:0]  mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [31:0] mem_wmask,
  input  wire logic        margin_start,
  output logic [31:0]      mem_rdata = 32'h0000_0000,
  output logic             margin_done = 1'b0
);
  logic [31:0] mem [128];
  logic [2:0]  busy_reg = 3'h0;
  initial for (int i = 0; i < 128; i++) mem[i] = 32'hA5A5_0000 | 32'(i);
  always @(posedge sys_clk) begin
    if (mem_req && mem_we) mem[mem_addr] <= mem[mem_addr] & ~mem_wmask | mem_wdata & mem_wmask;
    // idle bus toggles so stale data is never mistaken for valid
    mem_rdata <= mem_req ? mem[mem_addr] : ~mem_rdata;
    margin_done <= busy_reg == 3'h1;
    busy_reg <= margin_start ? 3'h6 : busy_reg - {2'h0, busy_reg != 3'h0};
  end
endmodule : mpp_mem_model
`default_nettype wire

// ### tb/mpp_port_props.sv
// assertions on the ports of the programming port
`timescale 1ns/1ps
`default_nettype none
module mpp_port_chk #(
  parameter int unsigned KEY_WINDOW_CYCLES = 2000
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       prog_data_out,
  input wire logic       prog_data_oe,
  input wire logic [2:0] dev_lock,
  input wire logic       mem_req,
  input wire logic       mem_we,
  input wire logic [1:0] mem_region,
  input wire logic [6:0] mem_addr,
  input wire logic       margin_start,
  input wire logic       unlocked,
  input wire logic       key_window_open
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] cyc_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) cyc_reg <= 32'h0000_0000;
    else if (!cyc_reg[31]) cyc_reg <= cyc_reg + 32'h0000_0001;
  end
  sequence s_wr;
    mem_req && mem_we;
  endsequence
  idle_low_a: assert property (!prog_data_oe |-> !prog_data_out)
    else $error("line high while released");
  quiet_write_a: assert property (s_wr |=> !prog_data_oe [*8])
    else $error("reply after write");
  write_unlock_a: assert property (s_wr |-> unlocked)
    else $error("write while locked");
  lock_write_a: assert property (s_wr |-> dev_lock != 3'h5 &&
    dev_lock != 3'h6 && !(dev_lock == 3'h3 && mem_region == 2'h0))
    else $error("write despite lock mode");
  factory_ro_a: assert property (s_wr |-> mem_addr[6] || mem_addr[4:0] > 5'h01)
    else $error("factory row written");
  region_map_a: assert property (mem_req |->
    mem_region == (mem_addr[6] ? 2'h2 : {1'b0, mem_addr[5]})) else $error("bad region");
  margin_unlock_a: assert property (margin_start |-> unlocked ##1 !margin_start)
    else $error("margin start wrong");
  window_end_a: assert property (cyc_reg > KEY_WINDOW_CYCLES + 1 |-> !key_window_open)
    else $error("key window too long");
endmodule : mpp_port_chk
bind mpp_port mpp_port_chk #(.KEY_WINDOW_CYCLES(KEY_WINDOW_CYCLES)) u_chk (.*);
`default_nettype wire

// ### tb/testbench.sv
// bench sending manchester frames to the programming port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk, rstn, prog_en, ctl_line, prog_data_out, prog_data_oe, mem_req, mem_we;
  logic        margin_start, margin_done, unlocked, key_window_open, got;
  logic [1:0]  die_addr, mem_region, margin_mode;
  logic [2:0]  dev_lock;
  logic [2:0]  modes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
  logic [3:0]  cs;
  logic [6:0]  mem_addr;
  logic [31:0] mem_wdata, mem_wmask, mem_rdata, rv;
  logic [25:0] margin_result_data, margin_result_status;
  int          fails, total_checks;
  wire logic   prog_data_in = prog_data_oe ? prog_data_out : ctl_line;
  mpp_port #(.KEY_WINDOW_CYCLES(8000)) dut (.*);
  mpp_mem_model u_mem (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [2:0] nxt(input logic [2:0] c, input logic b);
    return {c[1], c[0] ^ c[2] ^ b, c[2] ^ b};
  endfunction : nxt
  task automatic half(input logic v);
    ctl_line <= v;
    repeat (4) @(posedge sys_clk);
  endtask : half
  task automatic tx(input logic rd, input logic [45:0] v, input logic [2:0] bad);
    logic [2:0] c;
    c = 3'h7;
    repeat (4) half(1'b0);
    repeat (2) begin
      half(1'b0);
      half(1'b1);
    end
    for (int i = 45; i >= (rd ? 32 : 0); i--) begin
      c = nxt(c, v[i]);
      half(v[i]);
      half(~v[i]);
    end
    c = c ^ bad;
    for (int i = 2; i >= 0; i--) begin
      half(c[i]);
      half(~c[i]);
    end
    // dropping the line early would read as an extra bit
    repeat (12) @(posedge sys_clk);
    ctl_line <= 1'b0;
    @(posedge sys_clk);
  endtask : tx
  task automatic wr(input logic [6:0] a, input logic [1:0] fs, input logic [31:0] d,
                    input logic [2:0] bad);
    tx(1'b0, {1'b0, cs, fs, a, d}, bad);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [1:0] fs, input logic want);
    logic [36:0] r;
    logic [2:0]  c;
    got = 1'b0;
    r = 37'h0;
    tx(1'b1, {1'b1, cs, fs, a, 32'h0000_0000}, 3'h0);
    for (int i = 0; i < 300 && got !== 1'b1; i++) begin
      @(negedge sys_clk);
      got = prog_data_oe;
    end
    // first half level at our rate
    for (int i = 0; i < 37 && got === 1'b1; i++) begin
      repeat (i == 0 ? 1 : 8) @(negedge sys_clk);
      r = {r[35:0], prog_data_out};
    end
    repeat (9) @(posedge sys_clk);
    c = 3'h7;
    for (int i = 34; i >= 3; i--) c = nxt(c, r[i]);
    rv = r[34:3];
    chk("reply", {31'h0, got}, {31'h0, want});
    if (got === 1'b1) chk("sync crc", {27'h0, r[36:35], r[2:0]}, {29'h0, c});
    if (want && got !== 1'b1) wrap_up();
  endtask : rd
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    rstn = 1'b0;
    prog_en = 1'b0;
    ctl_line = 1'b0;
    die_addr = 2'h2;
    dev_lock = 3'h0;
    margin_result_data = 26'h155_5555;
    margin_result_status = 26'h000_0001;
    cs = 4'h4;
    fails = 0;
    total_checks = 0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    prog_en <= 1'b1;
    rd(7'h05, 2'h0, 1'b1);
    chk("r05", rv, 32'hA5A5_0005);
    rd(7'h45, 2'h2, 1'b1);
    chk("r45 high", rv, 32'h01A5_0000);
    cs = 4'h1;
    rd(7'h05, 2'h1, 1'b0);
    cs = 4'hF;
    rd(7'h05, 2'h1, 1'b1);
    chk("r05 low", rv, 32'h0000_0005);
    $display("test reads done");
    cs = 4'h0;
    wr(7'h05, 2'h0, 32'h0000_0000, 3'h0);
    rd(7'h05, 2'h0, 1'b1);
    chk("r05 locked", rv, 32'hA5A5_0005);
    cs = 4'h1;
    wr(mpp_pkg::KEY_ADDR, 2'h0, mpp_pkg::KEY_DATA, 3'h0);
    chk("foreign key", {31'h0, unlocked}, 32'h0);
    cs = 4'h4;
    wr(mpp_pkg::KEY_ADDR, 2'h0, mpp_pkg::KEY_DATA, 3'h0);
    chk("unlock", {31'h0, unlocked}, 32'h1);
    $display("test unlock done");
    wr(7'h05, 2'h0, 32'h0000_0000, 3'h1);
    wr(7'h05, 2'h3, 32'h0000_0000, 3'h0);
    wr(7'h05, 2'h2, 32'hFFFF_FFFF, 3'h0);
    wr(7'h01, 2'h0, 32'h0000_0000, 3'h0);
    rd(7'h05, 2'h0, 1'b1);
    chk("r05 part", rv, 32'hA7FF_F005);
    rd(7'h01, 2'h0, 1'b1);
    chk("r01", rv, 32'hA5A5_0001);
    $display("test writes done");
    foreach (modes[i]) begin
      dev_lock <= modes[i];
      wr(7'h07, 2'h0, {29'h0, modes[i]}, 3'h0);
      rd(7'h07, 2'h0, 1'b1);
      chk("open lock", rv, {29'h0, modes[i]});
    end
    dev_lock <= 3'h3;
    wr(7'h06, 2'h0, 32'h0000_0000, 3'h0);
    wr(7'h46, 2'h0, 32'h0000_0000, 3'h0);
    rd(7'h06, 2'h0, 1'b1);
    chk("r06", rv, 32'hA5A5_0006);
    rd(7'h46, 2'h0, 1'b1);
    chk("r46", rv, 32'h0000_0000);
    dev_lock <= 3'h6;
    wr(7'h46, 2'h0, 32'hFFFF_FFFF, 3'h0);
    rd(7'h46, 2'h0, 1'b1);
    chk("r46 ro", rv, 32'h0000_0000);
    dev_lock <= 3'h5;
    rd(7'h46, 2'h0, 1'b0);
    $display("test locks done");
    dev_lock <= 3'h0;
    wr(7'h43, 2'h0, 32'h0000_0003, 3'h0);
    chk("mode", {30'h0, margin_mode}, 32'h1);
    rd(7'h41, 2'h0, 1'b1);
    chk("r41", rv, 32'h0155_5555);
    rd(7'h43, 2'h0, 1'b1);
    chk("r43", rv, 32'h0000_0002);
    chk("window", {31'h0, key_window_open}, 32'h0);
    $display("test margin done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
